//--- logic/sewc_consts.svh
// Constants shared by both ends of the serial EEPROM write link
`ifndef SEWC_CONSTS_SVH
`define SEWC_CONSTS_SVH

// ==========================================================
// Word and address layout
`define SEWC_WORD_W 16
`define SEWC_ADDR_W 6
`define SEWC_OP_W 2
`define SEWC_HEAD_W 4

// ==========================================================
// Opcodes and extended codes (first two address bits)
`define SEWC_OP_EXT 2'h0
`define SEWC_OP_WRITE 2'h1
`define SEWC_OP_ERASE 2'h3
`define SEWC_EXT_DISABLE 2'h0
`define SEWC_EXT_WRALL 2'h1
`define SEWC_EXT_ERALL 2'h2
`define SEWC_EXT_ENABLE 2'h3

// ==========================================================
// Pin sample vector positions
`define SEWC_PIN_CS 0
`define SEWC_PIN_SK 1
`define SEWC_PIN_DI 2
`define SEWC_PIN_LOW 3
`define SEWC_PIN_N 4

// ==========================================================
// Timing
`define SEWC_CLK_MHZ 10
`define SEWC_WRITE_CYCLE_TIME_US 8000
`define SEWC_PROG_CYCLES (`SEWC_WRITE_CYCLE_TIME_US * `SEWC_CLK_MHZ)
`define SEWC_HOST_HALF 5
`define SEWC_HOST_GAP 6

`endif

//--- logic/sewc_pkg.sv
// Types shared by both ends of the serial EEPROM write link
package sewc_pkg;

	// ==========================================================
	// Device states and write kinds
	typedef enum logic [1:0] {
		DEV_STANDBY = 2'b00,
		DEV_SHIFT = 2'b01,
		DEV_PROG = 2'b10
	} sewc_dev_state_t;

	typedef enum logic [1:0] {
		WK_WORD = 2'b00,
		WK_ERASE = 2'b01,
		WK_ALL = 2'b10,
		WK_ERALL = 2'b11
	} sewc_wkind_t;

	// ==========================================================
	// Host commands and states
	typedef enum logic [2:0] {
		HOP_WRITE = 3'b000,
		HOP_ERASE = 3'b001,
		HOP_WRALL = 3'b010,
		HOP_ERALL = 3'b011,
		HOP_ENABLE = 3'b100,
		HOP_DISABLE = 3'b101
	} sewc_op_t;

	typedef enum logic [2:0] {
		HST_IDLE = 3'b000,
		HST_SHIFT = 3'b001,
		HST_GAP = 3'b010,
		HST_VERIFY = 3'b011,
		HST_END = 3'b100
	} sewc_host_state_t;

endpackage : sewc_pkg

//--- logic/sewc_if.sv
// Four-wire link between host and EEPROM device
`timescale 1ns/1ps
`default_nettype none

interface sewc_if;
	logic chip_select;
	logic serial_clock;
	logic serial_in;
	logic serial_out_o;
	logic serial_out_oe_n;
	logic serial_out;

	// Released output reads low
	assign serial_out = serial_out_oe_n ? 1'b0 : serial_out_o;

	modport device (
		input chip_select,
		input serial_clock,
		input serial_in,
		output serial_out_o,
		output serial_out_oe_n
	);

	modport host (
		output chip_select,
		output serial_clock,
		output serial_in,
		input serial_out
	);
endinterface : sewc_if

`default_nettype wire

//--- logic/sewc_device.sv
// EEPROM device end: pin filter, command decode, write control, verify
`timescale 1ns/1ps
`default_nettype none
`include "sewc_consts.svh"

module sewc_device
	import sewc_pkg::*;
#(
	parameter int ADDR_W = `SEWC_ADDR_W,
	parameter int PROG_CYCLES = `SEWC_PROG_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// Serial link
	sewc_if.device link,
	// Supply detector
	input wire logic supply_low_in,
	// Array peek and status
	input wire logic [ADDR_W-1:0] rd_addr_in,
	output logic [`SEWC_WORD_W-1:0] rd_data_out,
	output logic prog_enable_out,
	output logic busy_out
);

	// ==========================================================
	// Sizes
	localparam int WORDS = 2 ** ADDR_W;
	localparam int WW = `SEWC_WORD_W;
	localparam int NE = `SEWC_OP_W + ADDR_W;
	localparam int NW = NE + WW;
	localparam int CW = $clog2(NW + 2);
	localparam int PW = $clog2(PROG_CYCLES + 1);
	localparam int HW = `SEWC_HEAD_W;
	localparam int OW = `SEWC_OP_W;

	typedef struct packed {
		logic [WORDS-1:0][WW-1:0] mem;
		sewc_dev_state_t state;
		logic [`SEWC_PIN_N-1:0] s1;
		logic [`SEWC_PIN_N-1:0] s2;
		logic [`SEWC_PIN_N-1:0] s3;
		logic [`SEWC_PIN_N-1:0] f;
		logic [NW-1:0] sh;
		logic [CW-1:0] cnt;
		logic [HW-1:0] head;
		logic pen;
		logic verify;
		logic busy;
		logic [PW-1:0] pcnt;
		sewc_wkind_t kind;
		logic [ADDR_W-1:0] addr;
		logic [WW-1:0] data;
		logic do_val;
		logic do_oe_n;
		logic [WW-1:0] rdata;
	} sewc_dev_st_t;

	sewc_dev_st_t q;
	sewc_dev_st_t d;

	// ==========================================================
	// Next state
	always_comb begin
		logic sk_rise;
		logic cs_hi;
		logic low;
		logic di;
		logic [OW-1:0] op;
		logic [OW-1:0] ext;
		logic wr;
		sk_rise = 1'b0;
		cs_hi = 1'b0;
		low = 1'b0;
		di = 1'b0;
		op = '0;
		ext = '0;
		wr = 1'b0;
		d = q;
		d.s1 = {supply_low_in, link.serial_in, link.serial_clock,
			link.chip_select};
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < `SEWC_PIN_N; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.f[i] = q.s2[i];
			end
		end
		sk_rise = d.f[`SEWC_PIN_SK] & ~q.f[`SEWC_PIN_SK];
		cs_hi = d.f[`SEWC_PIN_CS];
		low = d.f[`SEWC_PIN_LOW];
		di = d.f[`SEWC_PIN_DI];
		op = q.head[HW-1 -: OW];
		ext = q.head[OW-1:0];

		unique case (q.state)
			DEV_STANDBY: begin
				if (cs_hi && sk_rise && di) begin
					d.state = DEV_SHIFT;
					d.cnt = '0;
					d.verify = 1'b0;
				end
			end
			DEV_SHIFT: begin
				if (!cs_hi) begin
					d.state = DEV_STANDBY;
					if (op == `SEWC_OP_WRITE && q.cnt == CW'(NW)) begin
						wr = 1'b1;
						d.kind = WK_WORD;
						d.addr = q.sh[WW +: ADDR_W];
						d.data = q.sh[WW-1:0];
					end else if (op == `SEWC_OP_ERASE && q.cnt == CW'(NE)) begin
						wr = 1'b1;
						d.kind = WK_ERASE;
						d.addr = q.sh[ADDR_W-1:0];
					end else if (op == `SEWC_OP_EXT) begin
						if (ext == `SEWC_EXT_WRALL && q.cnt == CW'(NW)) begin
							wr = 1'b1;
							d.kind = WK_ALL;
							d.data = q.sh[WW-1:0];
						end else if (ext == `SEWC_EXT_ERALL &&
							q.cnt == CW'(NE)) begin
							wr = 1'b1;
							d.kind = WK_ERALL;
						end else if (q.cnt >= CW'(HW)) begin
							if (ext == `SEWC_EXT_ENABLE) begin
								d.pen = 1'b1;
							end
							if (ext == `SEWC_EXT_DISABLE) begin
								d.pen = 1'b0;
							end
						end
					end
					if (wr && q.pen && !low) begin
						d.state = DEV_PROG;
						d.pcnt = '0;
						d.verify = 1'b1;
					end
				end else if (sk_rise) begin
					d.sh = {q.sh[NW-2:0], di};
					if (q.cnt != CW'(NW + 1)) begin
						d.cnt = q.cnt + 1'b1;
					end
					if (q.cnt == CW'(HW - 1)) begin
						d.head = {q.sh[HW-2:0], di};
					end
				end
			end
			DEV_PROG: begin
				d.pcnt = q.pcnt + 1'b1;
				if (q.pcnt == PW'(PROG_CYCLES - 1)) begin
					d.state = DEV_STANDBY;
					for (int i = 0; i < WORDS; i++) begin
						if (q.kind == WK_ALL || q.kind == WK_ERALL ||
							q.addr == ADDR_W'(i)) begin
							if (q.kind == WK_ERASE || q.kind == WK_ERALL) begin
								d.mem[i] = '1;
							end else begin
								d.mem[i] = q.data;
							end
						end
					end
				end
			end
		endcase

		if (low) begin
			d.pen = 1'b0;
			if (q.state == DEV_PROG) begin
				d.state = DEV_STANDBY;
				d.verify = 1'b0;
				d.mem = q.mem;
			end
		end

		if (cs_hi && d.verify) begin
			d.do_oe_n = 1'b0;
			d.do_val = (d.state != DEV_PROG);
		end else begin
			d.do_oe_n = 1'b1;
			d.do_val = 1'b0;
		end
		d.busy = (d.state == DEV_PROG);
		d.rdata = q.mem[rd_addr_in];
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			q <= '0;
			q.mem <= '1;
			q.do_oe_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	assign link.serial_out_o = q.do_val;
	assign link.serial_out_oe_n = q.do_oe_n;
	assign rd_data_out = q.rdata;
	assign prog_enable_out = q.pen;
	assign busy_out = q.busy;

endmodule : sewc_device

`default_nettype wire

//--- logic/sewc_host.sv
// Host end: frames commands onto the link and waits out programming
`timescale 1ns/1ps
`default_nettype none
`include "sewc_consts.svh"

module sewc_host
	import sewc_pkg::*;
#(
	parameter int ADDR_W = `SEWC_ADDR_W,
	parameter int HALF = `SEWC_HOST_HALF,
	parameter int GAP = `SEWC_HOST_GAP
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// Serial link
	sewc_if.host link,
	// Command port
	input wire logic cmd_valid_in,
	input wire sewc_op_t cmd_op_in,
	input wire logic [ADDR_W-1:0] cmd_addr_in,
	input wire logic [`SEWC_WORD_W-1:0] cmd_data_in,
	output logic cmd_ready_out,
	output logic done_out
);

	// ==========================================================
	// Sizes
	localparam int WW = `SEWC_WORD_W;
	localparam int FW = 1 + `SEWC_OP_W + ADDR_W + WW;
	localparam int BW = $clog2(FW + 1);
	localparam int DW = $clog2(2 * HALF + GAP + 1);

	typedef struct packed {
		sewc_host_state_t state;
		logic [FW-1:0] frame;
		logic [BW-1:0] nbits;
		logic [BW-1:0] bits;
		logic [DW-1:0] div;
		logic cs;
		logic sk;
		logic di;
		logic wtype;
		logic s1;
		logic s2;
		logic ready;
		logic done;
	} sewc_host_st_t;

	sewc_host_st_t q;
	sewc_host_st_t d;

	// ==========================================================
	// Next state
	always_comb begin
		logic [`SEWC_OP_W-1:0] opx;
		logic [ADDR_W-1:0] ax;
		logic long_f;
		logic wt;
		opx = `SEWC_OP_EXT;
		ax = cmd_addr_in;
		long_f = 1'b0;
		wt = 1'b0;
		d = q;
		d.s1 = link.serial_out;
		d.s2 = q.s1;
		d.done = 1'b0;
		unique case (cmd_op_in)
			HOP_WRITE: begin
				opx = `SEWC_OP_WRITE;
				long_f = 1'b1;
				wt = 1'b1;
			end
			HOP_ERASE: begin
				opx = `SEWC_OP_ERASE;
				wt = 1'b1;
			end
			HOP_WRALL: begin
				ax = {`SEWC_EXT_WRALL, {(ADDR_W - `SEWC_OP_W){1'b0}}};
				long_f = 1'b1;
				wt = 1'b1;
			end
			HOP_ERALL: begin
				ax = {`SEWC_EXT_ERALL, {(ADDR_W - `SEWC_OP_W){1'b0}}};
				wt = 1'b1;
			end
			HOP_ENABLE: begin
				ax = {`SEWC_EXT_ENABLE, {(ADDR_W - `SEWC_OP_W){1'b0}}};
			end
			default: begin
				ax = {`SEWC_EXT_DISABLE, {(ADDR_W - `SEWC_OP_W){1'b0}}};
			end
		endcase

		unique case (q.state)
			HST_IDLE: begin
				d.cs = 1'b0;
				d.ready = 1'b1;
				if (cmd_valid_in) begin
					d.ready = 1'b0;
					d.state = HST_SHIFT;
					d.frame = {1'b1, opx, ax, cmd_data_in};
					d.nbits = long_f ? BW'(FW) : BW'(FW - WW);
					d.bits = '0;
					d.div = '0;
					d.wtype = wt;
					d.cs = 1'b1;
				end
			end
			HST_SHIFT: begin
				d.di = q.frame[FW-1];
				d.div = q.div + 1'b1;
				if (q.div == DW'(HALF - 1)) begin
					d.sk = 1'b1;
				end
				if (q.div == DW'(2 * HALF - 1)) begin
					d.sk = 1'b0;
					d.div = '0;
					d.frame = {q.frame[FW-2:0], 1'b0};
					d.bits = q.bits + 1'b1;
					if (q.bits == q.nbits - 1'b1) begin
						d.state = HST_GAP;
						d.cs = 1'b0;
						d.di = 1'b0;
					end
				end
			end
			HST_GAP: begin
				d.div = q.div + 1'b1;
				if (q.div == DW'(GAP - 1)) begin
					d.div = '0;
					d.state = q.wtype ? HST_VERIFY : HST_END;
					d.cs = q.wtype;
				end
			end
			HST_VERIFY: begin
				d.di = 1'b0;
				if (q.s2) begin
					d.cs = 1'b0;
					d.state = HST_END;
				end
			end
			HST_END: begin
				d.div = q.div + 1'b1;
				if (q.div == DW'(GAP - 1)) begin
					d.div = '0;
					d.done = 1'b1;
					d.ready = 1'b1;
					d.state = HST_IDLE;
				end
			end
			default: begin
				d.state = HST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	assign link.chip_select = q.cs;
	assign link.serial_clock = q.sk;
	assign link.serial_in = q.di;
	assign cmd_ready_out = q.ready;
	assign done_out = q.done;

endmodule : sewc_host

`default_nettype wire

//--- sim/sewc_link_asserts.sv
// Link checker for the serial EEPROM write link
`timescale 1ns/1ps
`default_nettype none

module sewc_link_asserts (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// Link signals
	input wire logic chip_select,
	input wire logic serial_clock,
	input wire logic serial_in,
	input wire logic serial_out_o,
	input wire logic serial_out_oe_n
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);

	// ==========================================================
	// Device side
	a_idle_release: assert property (
		!chip_select [*6] |-> serial_out_oe_n)
		else $error("output driven while deselected");
	a_busy_bounded: assert property (
		chip_select && !serial_out_oe_n && !serial_out_o
		|-> ##[1:70] (serial_out_o || serial_out_oe_n))
		else $error("busy shown too long");
	a_ready_start: assert property (
		chip_select && serial_in && $rose(serial_clock) && serial_out_o
		&& !serial_out_oe_n |-> ##[1:8] serial_out_oe_n)
		else $error("output not released after start bit");

	// ==========================================================
	// Host side
	a_busy_quiet: assert property (
		chip_select && !serial_out_oe_n && !serial_out_o
		|-> !serial_in && !serial_clock)
		else $error("host active during busy");
	a_idle_lines: assert property (
		!chip_select |-> !serial_clock && !serial_in)
		else $error("clock or data moving while deselected");
	a_clk_high: assert property (
		$rose(serial_clock) |=> serial_clock [*4] ##1 !serial_clock)
		else $error("serial clock high phase wrong");
	a_data_hold: assert property (
		$rose(serial_clock) |=> $stable(serial_in) [*4])
		else $error("data changed while clock high");
	a_cs_gap: assert property (
		$fell(chip_select) |=> !chip_select [*3])
		else $error("deselect gap too short");
endmodule : sewc_link_asserts

`default_nettype wire

//--- sim/test_serial_eeprom_write_control.sv
// Self-checking bench for the serial EEPROM write link
`timescale 1ns/1ps
`default_nettype none

module test_serial_eeprom_write_control import sewc_pkg::*;;
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic host_resetn = 1'b0;
	logic supply_low_in = 1'b0;
	logic [5:0] rd_addr_in = 6'h00;
	logic [15:0] rd_data_out;
	logic prog_enable_out;
	logic busy_out;
	logic cmd_valid_in = 1'b0;
	sewc_op_t cmd_op_in = HOP_DISABLE;
	logic [5:0] cmd_addr_in = 6'h00;
	logic [15:0] cmd_data_in = 16'h0000;
	logic cmd_ready_out;
	logic done_out;
	int mismatches = 0;
	int total_checks = 0;

	always #50 sys_clk_in = ~sys_clk_in;

	// ==========================================================
	// Both ends and checker
	sewc_if link ();
	sewc_device #(.PROG_CYCLES(50)) u_sewc_device (
		.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .link(link),
		.supply_low_in(supply_low_in), .rd_addr_in(rd_addr_in),
		.rd_data_out(rd_data_out), .prog_enable_out(prog_enable_out),
		.busy_out(busy_out));
	sewc_host u_sewc_host (
		.sys_clk_in(sys_clk_in), .resetn_in(host_resetn), .link(link),
		.cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
		.cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
		.cmd_ready_out(cmd_ready_out), .done_out(done_out));
	sewc_link_asserts u_sewc_link_asserts (
		.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
		.chip_select(link.chip_select), .serial_clock(link.serial_clock),
		.serial_in(link.serial_in), .serial_out_o(link.serial_out_o),
		.serial_out_oe_n(link.serial_out_oe_n));

	// ==========================================================
	// Tasks
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check

	// Refused writes may leave the host waiting; reset it alone
	task automatic cmd(input sewc_op_t op, input logic [5:0] a,
		input logic [15:0] d, input logic exp_busy);
		int n;
		logic hit;
		n = 0;
		hit = 1'b0;
		while (cmd_ready_out !== 1'b1) @(negedge sys_clk_in);
		cmd_op_in = op;
		cmd_addr_in = a;
		cmd_data_in = d;
		cmd_valid_in = 1'b1;
		@(negedge sys_clk_in);
		cmd_valid_in = 1'b0;
		while (done_out !== 1'b1 && n < 2000) begin
			@(negedge sys_clk_in);
			hit = hit | busy_out;
			n++;
		end
		check("busy", {15'h0, hit}, {15'h0, exp_busy});
		if (op >= HOP_ENABLE || exp_busy)
			check("done", {15'h0, done_out}, 16'h0001);
		if (done_out !== 1'b1) begin
			host_resetn = 1'b0;
			repeat (2) @(negedge sys_clk_in);
			host_resetn = 1'b1;
		end
	endtask : cmd

	// Cuts a write short: host reset mid-frame, or low supply mid-write
	task automatic cut(input sewc_op_t op, input logic [5:0] a,
		input logic [15:0] d, input int at, input logic low);
		logic hit;
		hit = 1'b0;
		while (cmd_ready_out !== 1'b1) @(negedge sys_clk_in);
		cmd_op_in = op;
		cmd_addr_in = a;
		cmd_data_in = d;
		cmd_valid_in = 1'b1;
		@(negedge sys_clk_in);
		cmd_valid_in = 1'b0;
		repeat (at) @(negedge sys_clk_in);
		if (low) begin
			check("busy before dip", {15'h0, busy_out}, 16'h0001);
			supply_low_in = 1'b1;
		end
		repeat (8) @(negedge sys_clk_in);
		host_resetn = 1'b0;
		repeat (2) @(negedge sys_clk_in);
		host_resetn = 1'b1;
		repeat (80) begin
			@(negedge sys_clk_in);
			hit = hit | busy_out;
		end
		check("busy after cut", {15'h0, hit}, 16'h0000);
		check("enable after cut", {15'h0, prog_enable_out},
			{15'h0, ~low});
		supply_low_in = 1'b0;
	endtask : cut

	task automatic rd(input logic [5:0] a, input logic [15:0] exp);
		rd_addr_in = a;
		repeat (2) @(negedge sys_clk_in);
		check("array word", rd_data_out, exp);
	endtask : rd

	task automatic en(input logic exp);
		repeat (8) @(negedge sys_clk_in);
		check("prog enable", {15'h0, prog_enable_out}, {15'h0, exp});
	endtask : en

	task automatic results();
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	// ==========================================================
	// Sequence
	initial begin
		repeat (8) @(negedge sys_clk_in);
		resetn_in = 1'b1;
		host_resetn = 1'b1;
		rd(6'h00, 16'hffff);
		cmd(HOP_DISABLE, 6'h00, 16'h0000, 1'b0);
		en(1'b0);
		cmd(HOP_WRITE, 6'h05, 16'h1234, 1'b0);
		rd(6'h05, 16'hffff);
		cmd(HOP_ENABLE, 6'h00, 16'h0000, 1'b0);
		en(1'b1);
		cmd(HOP_WRITE, 6'h05, 16'h1234, 1'b1);
		rd(6'h05, 16'h1234);
		rd(6'h04, 16'hffff);
		cmd(HOP_WRITE, 6'h05, 16'h0f0f, 1'b1);
		rd(6'h05, 16'h0f0f);
		cmd(HOP_ERASE, 6'h05, 16'h0000, 1'b1);
		rd(6'h05, 16'hffff);
		cmd(HOP_WRALL, 6'h2a, 16'ha5c3, 1'b1);
		rd(6'h00, 16'ha5c3);
		rd(6'h3f, 16'ha5c3);
		cmd(HOP_ERALL, 6'h11, 16'h0000, 1'b1);
		rd(6'h00, 16'hffff);
		rd(6'h3f, 16'hffff);
		cut(HOP_WRITE, 6'h05, 16'h0000, 103, 1'b0);
		rd(6'h05, 16'hffff);
		cmd(HOP_DISABLE, 6'h00, 16'h0000, 1'b0);
		en(1'b0);
		cmd(HOP_WRITE, 6'h3f, 16'h1111, 1'b0);
		rd(6'h3f, 16'hffff);
		cmd(HOP_ENABLE, 6'h00, 16'h0000, 1'b0);
		supply_low_in = 1'b1;
		en(1'b0);
		cmd(HOP_WRITE, 6'h3f, 16'h2222, 1'b0);
		rd(6'h3f, 16'hffff);
		supply_low_in = 1'b0;
		cmd(HOP_WRITE, 6'h3f, 16'h3333, 1'b0);
		rd(6'h3f, 16'hffff);
		cmd(HOP_ENABLE, 6'h00, 16'h0000, 1'b0);
		cmd(HOP_WRITE, 6'h3f, 16'h8001, 1'b1);
		rd(6'h3f, 16'h8001);
		cut(HOP_WRITE, 6'h3f, 16'h7777, 280, 1'b1);
		rd(6'h3f, 16'h8001);
		cmd(HOP_DISABLE, 6'h00, 16'h0000, 1'b0);
		en(1'b0);
		results();
	end

	// Cuts a hang short
	initial begin
		#5000000;
		mismatches++;
		results();
	end
endmodule : test_serial_eeprom_write_control

`default_nettype wire
